// [rtl/ssm_consts.svh]
// Offsets, field positions and reset values of the stop-mode controller
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH
// Register byte offsets
`define SSM_A_CTRL   8'h00
`define SSM_A_MODE   8'h04
`define SSM_A_CW     8'h08
`define SSM_A_DLY    8'h0C
`define SSM_A_STAT   8'h10
// CTRL fields
`define SSM_C_ENA    0
`define SSM_C_AUXES  1
`define SSM_C_BRAKE  2
`define SSM_C_FPOL   3
`define SSM_C_RPOL   4
`define SSM_CTRL_W   5
// MODE fields
`define SSM_M_SOFF   2:0
`define SSM_M_ESTOP  5:3
`define SSM_M_QSTOP  8:6
`define SSM_M_HALT   11:9
`define SSM_M_F1     13:12
`define SSM_M_F2     16:14
`define SSM_MODE_W   17
// Control word bits
`define SSM_CW_QS    2
`define SSM_CW_HALT  8
// Reset values
`define SSM_CW_RST   16'h0004
`define SSM_DLY_RST  16'h0064
// Bus responses
`define SSM_OKAY     2'h0
`define SSM_SLVERR   2'h2
`endif

// [rtl/ssm_pkg.sv]
// Types of the stop-mode controller
package ssm_pkg;
   typedef enum logic [1:0] {
      SSM_RUN  = 2'h0,
      SSM_STOP = 2'h1,
      SSM_BRKW = 2'h2,
      SSM_HOLD = 2'h3
   } ssm_phase_t;

   // Lower code outranks higher code
   typedef enum logic [2:0] {
      SSM_C_F1    = 3'h0,
      SSM_C_F2    = 3'h1,
      SSM_C_ESTOP = 3'h2,
      SSM_C_LIMIT = 3'h3,
      SSM_C_SOFF  = 3'h4,
      SSM_C_QSTOP = 3'h5,
      SSM_C_HALT  = 3'h6,
      SSM_C_NONE  = 3'h7
   } ssm_cause_t;

   typedef enum logic [2:0] {
      SSM_S_COAST = 3'h0,
      SSM_S_ZERO  = 3'h1,
      SSM_S_RAMP  = 3'h2,
      SSM_S_RTRQ  = 3'h3,
      SSM_S_DB    = 3'h4
   } ssm_stop_t;

   typedef enum logic [1:0] {
      SSM_H_DEEN  = 2'h0,
      SSM_H_PLOCK = 2'h1,
      SSM_H_DB    = 2'h2
   } ssm_hold_t;

   typedef struct packed {
      logic energize;
      logic dyn_brake;
      logic pos_lock;
      logic zero_speed;
      logic ramp;
      logic rev_torque;
      logic fwd_inhibit;
      logic rev_inhibit;
      logic brake_engage;
      logic warn_estop;
      logic warn_limit;
      logic warn_other;
      logic fault;
   } ssm_out_t;

   typedef struct packed {
      logic [2:0]  fwd_s;
      logic [2:0]  rev_s;
      logic [2:0]  est_s;
      logic [2:0]  frs_s;
      logic        fwd_f;
      logic        rev_f;
      logic        est_f;
      logic        frs_f;
      logic        f1;
      logic        f2;
      ssm_phase_t  phase;
      ssm_cause_t  cause;
      ssm_stop_t   act;
      ssm_hold_t   hold;
      logic [15:0] cnt;
      logic [4:0]  ctrl;
      logic [16:0] mode;
      logic [15:0] cw;
      logic [15:0] dly;
      logic        aw_h;
      logic [7:0]  aw_a;
      logic        w_h;
      logic [31:0] w_d;
      logic [3:0]  w_s;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      ssm_out_t    o;
   } ssm_st_t;
endpackage : ssm_pkg

// [rtl/ssm_top.sv]
// Stop-event sequencer of a servo drive with an AXI4-Lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ssm_consts.svh"

module ssm_top
   import ssm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              fault_reset_input,
   input  wire logic              forward_limit_input,
   input  wire logic              reverse_limit_input,
   input  wire logic              emergency_halt_input,
   input  wire logic              fault_class1,
   input  wire logic              fault_class2,
   input  wire logic              warn_other,
   input  wire logic              motor_at_rest,
   input  wire logic              move_fwd_req,
   input  wire logic              move_rev_req,
   output logic                   drive_energize,
   output logic                   dyn_brake_on,
   output logic                   pos_lock_on,
   output logic                   zero_speed_cmd,
   output logic                   ramp_stop_cmd,
   output logic                   rev_torque_cmd,
   output logic                   fwd_inhibit,
   output logic                   rev_inhibit,
   output logic                   brake_engage,
   output logic                   warn_estop,
   output logic                   warn_limit,
   output logic                   warn_other_seen,
   output logic                   fault_active
);

   ssm_st_t    st_q;
   ssm_st_t    st_d;
   ssm_cause_t cause_w;
   ssm_stop_t  act_w;
   ssm_hold_t  hold_w;
   logic       frs_edge;
   logic       est_any;
   logic       lim_hit;

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // Event arbitration, highest rank first
   always_comb begin
      frs_edge = ~st_q.frs_f & st_q.frs_s[1] & st_q.frs_s[2];
      est_any  = st_q.est_f | st_q.ctrl[`SSM_C_AUXES];
      lim_hit  = (st_q.fwd_f & move_fwd_req)
               | (st_q.rev_f & move_rev_req);
      if (st_q.f1) begin
         cause_w = SSM_C_F1;
      end else if (st_q.f2) begin
         cause_w = SSM_C_F2;
      end else if (est_any) begin
         cause_w = SSM_C_ESTOP;
      end else if (lim_hit) begin
         cause_w = SSM_C_LIMIT;
      end else if (!st_q.ctrl[`SSM_C_ENA]) begin
         cause_w = SSM_C_SOFF;
      end else if (!st_q.cw[`SSM_CW_QS]) begin
         cause_w = SSM_C_QSTOP;
      end else if (st_q.cw[`SSM_CW_HALT]) begin
         cause_w = SSM_C_HALT;
      end else begin
         cause_w = SSM_C_NONE;
      end
   end

   // Stop action and hold state for the chosen event
   always_comb begin
      act_w  = SSM_S_ZERO;
      hold_w = SSM_H_PLOCK;
      case (cause_w)
         SSM_C_F1: begin
            // Codes 0..2: coast/deen, brake/deen, brake/brake
            act_w  = (st_q.mode[`SSM_M_F1] == 2'h0) ? SSM_S_COAST
                                                    : SSM_S_DB;
            hold_w = (st_q.mode[`SSM_M_F1] == 2'h2) ? SSM_H_DB
                                                    : SSM_H_DEEN;
         end
         SSM_C_F2: begin
            if (st_q.ctrl[`SSM_C_BRAKE]) begin
               act_w  = SSM_S_ZERO;
               hold_w = SSM_H_DB;
            end else begin
               case (st_q.mode[`SSM_M_F2])
                  3'h0:       act_w = SSM_S_COAST;
                  3'h1, 3'h2: act_w = SSM_S_ZERO;
                  default:    act_w = SSM_S_DB;
               endcase
               hold_w = (st_q.mode[`SSM_M_F2] inside {3'h2, 3'h3})
                      ? SSM_H_DB : SSM_H_DEEN;   // Codes 2, 3 hold braking
            end
         end
         SSM_C_ESTOP: begin
            act_w  = ssm_stop_t'(st_q.mode[`SSM_M_ESTOP]);
            hold_w = SSM_H_PLOCK;
         end
         SSM_C_LIMIT: act_w = SSM_S_ZERO;
         SSM_C_SOFF: begin
            act_w  = ssm_stop_t'(st_q.mode[`SSM_M_SOFF]);
            hold_w = SSM_H_DEEN;
         end
         SSM_C_QSTOP: act_w = ssm_stop_t'(st_q.mode[`SSM_M_QSTOP]);
         SSM_C_HALT:  act_w = ssm_stop_t'(st_q.mode[`SSM_M_HALT]);
         default:     act_w = SSM_S_ZERO;
      endcase
      // Codes above the last stop mode fall back to zero speed
      act_w = (act_w > SSM_S_DB) ? SSM_S_ZERO : act_w;
   end

   // Next state of everything
   always_comb begin
      st_d = st_q;
      // Pin inputs: three flops, accept when second and third agree
      st_d.fwd_s = {st_q.fwd_s[1:0], forward_limit_input};
      st_d.rev_s = {st_q.rev_s[1:0], reverse_limit_input};
      st_d.est_s = {st_q.est_s[1:0], emergency_halt_input};
      st_d.frs_s = {st_q.frs_s[1:0], fault_reset_input};
      if (st_q.fwd_s[1] == st_q.fwd_s[2]) begin
         st_d.fwd_f = st_q.fwd_s[2] ^ st_q.ctrl[`SSM_C_FPOL];
      end
      if (st_q.rev_s[1] == st_q.rev_s[2]) begin
         st_d.rev_f = st_q.rev_s[2] ^ st_q.ctrl[`SSM_C_RPOL];
      end
      if (st_q.est_s[1] == st_q.est_s[2]) begin
         st_d.est_f = st_q.est_s[2];
      end
      if (st_q.frs_s[1] == st_q.frs_s[2]) begin
         st_d.frs_f = st_q.frs_s[2];
      end

      // Fault latches: a new fault beats a reset edge in the same cycle
      st_d.f1 = fault_class1 | (st_q.f1 & ~(frs_edge & ~fault_class1));
      st_d.f2 = fault_class2 | (st_q.f2 & ~(frs_edge & ~fault_class2));

      // Stop sequencer
      case (st_q.phase)
         SSM_RUN: begin
            if (cause_w != SSM_C_NONE) begin
               st_d.phase = SSM_STOP;
               st_d.cause = cause_w;
               st_d.act   = act_w;
               st_d.hold  = hold_w;
            end
         end
         SSM_STOP, SSM_HOLD: begin
            if (cause_w == SSM_C_NONE) begin
               st_d.phase = SSM_RUN;
               st_d.cause = SSM_C_NONE;
            end else if (cause_w < st_q.cause) begin
               // A more severe event restarts the stop in its own mode
               st_d.phase = SSM_STOP;
               st_d.cause = cause_w;
               st_d.act   = act_w;
               st_d.hold  = hold_w;
            end else if (st_q.phase == SSM_STOP && motor_at_rest) begin
               if (st_q.ctrl[`SSM_C_BRAKE] && st_q.cause <= SSM_C_F2
                   && st_q.dly != 16'h0000) begin
                  st_d.phase = SSM_BRKW;
                  st_d.cnt   = st_q.dly;
               end else begin
                  st_d.phase = SSM_HOLD;
               end
            end
         end
         SSM_BRKW: begin
            // Power stays on until the brake has had time to bite
            if (cause_w < st_q.cause) begin
               st_d.phase = SSM_STOP;
               st_d.cause = cause_w;
               st_d.act   = act_w;
               st_d.hold  = hold_w;
            end else if (st_q.cnt <= 16'h0001) begin
               st_d.phase = SSM_HOLD;
               st_d.cnt   = 16'h0000;
            end else begin
               st_d.cnt   = st_q.cnt - 16'h0001;
            end
         end
         default: begin
            st_d.phase = SSM_STOP;
         end
      endcase

      // Drive outputs, taken from the next state so they leave flops
      st_d.o = '0;
      case (st_d.phase)
         SSM_RUN: begin
            st_d.o.energize = 1'b1;
         end
         SSM_STOP: begin
            st_d.o.energize   = !(st_d.act inside {SSM_S_COAST, SSM_S_DB});
            st_d.o.zero_speed = (st_d.act == SSM_S_ZERO);
            st_d.o.ramp       = (st_d.act == SSM_S_RAMP);
            st_d.o.rev_torque = (st_d.act == SSM_S_RTRQ);
            st_d.o.dyn_brake  = (st_d.act == SSM_S_DB);
         end
         SSM_BRKW: begin
            st_d.o.energize   = 1'b1;
            st_d.o.zero_speed = 1'b1;
         end
         default: begin
            st_d.o.energize  = (st_d.hold == SSM_H_PLOCK);
            st_d.o.pos_lock  = (st_d.hold == SSM_H_PLOCK);
            st_d.o.dyn_brake = (st_d.hold == SSM_H_DB);
         end
      endcase
      st_d.o.brake_engage = st_q.ctrl[`SSM_C_BRAKE]
                          && st_d.phase != SSM_RUN;
      st_d.o.fwd_inhibit  = st_d.fwd_f;
      st_d.o.rev_inhibit  = st_d.rev_f;
      st_d.o.warn_estop   = st_d.est_f | st_q.ctrl[`SSM_C_AUXES];
      st_d.o.warn_limit   = st_d.fwd_f | st_d.rev_f;
      st_d.o.warn_other   = warn_other;
      st_d.o.fault        = st_d.f1 | st_d.f2;

      // AXI4-Lite write: address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_h = 1'b1;
         st_d.aw_a = 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_h = 1'b1;
         st_d.w_d = s_axi_wdata;
         st_d.w_s = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_h && st_q.w_h && !st_q.bvalid) begin
         st_d.aw_h   = 1'b0;
         st_d.w_h    = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = `SSM_OKAY;
         case (st_q.aw_a)
            `SSM_A_CTRL: st_d.ctrl = `SSM_CTRL_W'(merge(
                  32'(st_q.ctrl), st_q.w_d, st_q.w_s));
            `SSM_A_MODE: st_d.mode = `SSM_MODE_W'(merge(
                  32'(st_q.mode), st_q.w_d, st_q.w_s));
            `SSM_A_CW:   st_d.cw = 16'(merge(
                  32'(st_q.cw), st_q.w_d, st_q.w_s));
            `SSM_A_DLY:  st_d.dly = 16'(merge(
                  32'(st_q.dly), st_q.w_d, st_q.w_s));
            `SSM_A_STAT: st_d.bresp = `SSM_OKAY;     // Read-only, ignored
            default:     st_d.bresp = `SSM_SLVERR;
         endcase
      end
      st_d.awready = !st_d.aw_h && !st_d.bvalid;
      st_d.wready  = !st_d.w_h && !st_d.bvalid;

      // AXI4-Lite read
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = `SSM_OKAY;
         case (8'(s_axi_araddr))
            `SSM_A_CTRL: st_d.rdata = 32'(st_q.ctrl);
            `SSM_A_MODE: st_d.rdata = 32'(st_q.mode);
            `SSM_A_CW:   st_d.rdata = 32'(st_q.cw);
            `SSM_A_DLY:  st_d.rdata = 32'(st_q.dly);
            `SSM_A_STAT: st_d.rdata = {7'h00, st_q.o, st_q.f2, st_q.f1,
                                       st_q.hold, st_q.act, st_q.cause,
                                       st_q.phase};
            default: begin
               st_d.rdata = 32'h00000000;
               st_d.rresp = `SSM_SLVERR;
            end
         endcase
      end
      st_d.arready = !st_d.rvalid;
   end

   // State register; only constants under reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q       <= '0;
         st_q.cw    <= `SSM_CW_RST;
         st_q.dly   <= `SSM_DLY_RST;
         st_q.phase <= SSM_STOP;
         st_q.cause <= SSM_C_SOFF;
      end else begin
         st_q <= st_d;
      end
   end

   // Ports straight from flops
   assign s_axi_awready   = st_q.awready;
   assign s_axi_wready    = st_q.wready;
   assign s_axi_bvalid    = st_q.bvalid;
   assign s_axi_bresp     = st_q.bresp;
   assign s_axi_arready   = st_q.arready;
   assign s_axi_rvalid    = st_q.rvalid;
   assign s_axi_rresp     = st_q.rresp;
   assign s_axi_rdata     = st_q.rdata;
   assign drive_energize  = st_q.o.energize;
   assign dyn_brake_on    = st_q.o.dyn_brake;
   assign pos_lock_on     = st_q.o.pos_lock;
   assign zero_speed_cmd  = st_q.o.zero_speed;
   assign ramp_stop_cmd   = st_q.o.ramp;
   assign rev_torque_cmd  = st_q.o.rev_torque;
   assign fwd_inhibit     = st_q.o.fwd_inhibit;
   assign rev_inhibit     = st_q.o.rev_inhibit;
   assign brake_engage    = st_q.o.brake_engage;
   assign warn_estop      = st_q.o.warn_estop;
   assign warn_limit      = st_q.o.warn_limit;
   assign warn_other_seen = st_q.o.warn_other;
   assign fault_active    = st_q.o.fault;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   fault_latch_a: assert property (
      st_q.f1 && !frs_edge |=> st_q.f1)
      else $error("class-one fault dropped without reset edge");
   warn_lock_a: assert property (st_q.phase == SSM_HOLD
      && st_q.cause == SSM_C_LIMIT |-> pos_lock_on && drive_energize)
      else $error("limit stop not held in position lock");
   coast_off_a: assert property (st_q.phase == SSM_STOP
      && st_q.act == SSM_S_COAST |-> !drive_energize)
      else $error("coast stop left motor powered");
   zero_cmd_a: assert property (st_q.phase == SSM_STOP
      && st_q.act == SSM_S_ZERO |-> zero_speed_cmd && drive_energize)
      else $error("zero-speed stop not commanded");
   db_hold_a: assert property (st_q.phase == SSM_HOLD
      && st_q.hold == SSM_H_DB |-> dyn_brake_on && !drive_energize)
      else $error("braking hold wrong");
   fwd_inh_a: assert property (st_q.fwd_s[2:1] == 2'b11
      && !st_q.ctrl[`SSM_C_FPOL] |=> fwd_inhibit)
      else $error("forward limit not inhibiting");
   qstop_go_a: assert property (st_q.phase == SSM_RUN
      && cause_w == SSM_C_QSTOP |=> st_q.phase == SSM_STOP
      && st_q.act == $past(act_w))
      else $error("quick stop not started");
   halt_go_a: assert property (st_q.phase == SSM_RUN
      && cause_w == SSM_C_HALT |=> st_q.phase == SSM_STOP)
      else $error("halt not started");
   brake_wait_a: assert property (st_q.phase == SSM_STOP
      && !st_q.ctrl[`SSM_C_BRAKE] |=> st_q.phase != SSM_BRKW)
      else $error("brake delay used without brake");
endmodule : ssm_top

// [verif/servo_stop_mode_controller_tb.sv]
// Self-checking bench of the stop-mode controller
`timescale 1ns/1ps
`include "ssm_consts.svh"
module servo_stop_mode_controller_tb
   import ssm_pkg::*;
;
   logic        clk = 0;
   logic        rst = 1;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, rdv;
   logic [3:0]  wst = 0;
   logic [1:0]  br, rr, rsp;
   logic        awv = 0, awr, wv = 0, wrd, bv, brd = 0;
   logic        arv = 0, arr, rv, rrd = 0;
   logic        frst = 0, flim = 0, rlim = 0, est = 0;
   logic        f1 = 0, f2 = 0, wo = 0, mf = 0, mr = 0, rest;
   logic        en, db, pl, zs, rp, rt, fi, ri, bk, we, wl, wos, fa;
   int          n_mismatch = 0, comparisons = 0, c, h;

   ssm_top uut (
      .clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
      .fault_reset_input(frst), .forward_limit_input(flim),
      .reverse_limit_input(rlim), .emergency_halt_input(est),
      .fault_class1(f1), .fault_class2(f2), .warn_other(wo),
      .motor_at_rest(rest), .move_fwd_req(mf), .move_rev_req(mr),
      .drive_energize(en), .dyn_brake_on(db), .pos_lock_on(pl),
      .zero_speed_cmd(zs), .ramp_stop_cmd(rp), .rev_torque_cmd(rt),
      .fwd_inhibit(fi), .rev_inhibit(ri), .brake_engage(bk),
      .warn_estop(we), .warn_limit(wl), .warn_other_seen(wos),
      .fault_active(fa)
   );

   ssm_motor_model mdl (
      .clk(clk), .rst(rst), .energize(en), .stopping(zs | rp | rt | db),
      .hold(pl), .at_rest(rest)
   );

   // 25 MHz clock
   always #20 clk = ~clk;

   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   // A bus wait that runs out ends the run at once
   task automatic limit(input int i);
      if (i >= 64) begin
         n_mismatch++;
         stop_test();
      end
   endtask : limit

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle

   // Address and data offered together, each dropped when taken
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      int i;
      awa <= a;
      wd <= d;
      wst <= 4'hF;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (bv) break;
      end
      rsp = br;
      limit(i);
   endtask : bw

   task automatic bread(input logic [7:0] a);
      int i;
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      rdv = rd;
      rsp = rr;
      limit(i);
   endtask : bread

   // Stop fields; enable-off coasts, emergency stops at zero speed
   function automatic logic [31:0] md(input logic [2:0] q, hl,
                                      input logic [1:0] a,
                                      input logic [2:0] b);
      return {15'h0, b, a, hl, q, 3'h1, 3'h0};
   endfunction : md

   // Expected {zero, ramp, reverse torque, braking} for a stop code
   function automatic logic [3:0] exp_cmd(input int s);
      return (s == 0) ? 4'h0 : 4'h8 >> (s - 1);
   endfunction : exp_cmd

   initial begin
      void'($urandom(32'hE8C2));
      settle(5);
      rst <= 1'b0;
      settle(2);
      bread(`SSM_A_CW);
      chk(rdv, 32'h0000_0004);
      bread(`SSM_A_DLY);
      chk(rdv, 32'h0000_0064);
      bread(8'h14);
      chk(rsp, `SSM_SLVERR);
      chk(rdv, 32'h0000_0000);
      bw(8'h14, 32'hFFFF_FFFF);
      chk(rsp, `SSM_SLVERR);
      bw(`SSM_A_CTRL, 32'h1);
      settle(3);
      chk(en, 1'b1);
      $display("registers done");
      // Every quick-stop code, each followed by a halt of random code
      for (c = 0; c < 5; c++) begin
         h = $urandom % 5;
         bw(`SSM_A_MODE, md(c[2:0], h[2:0], 2'h2, 3'h1));
         bw(`SSM_A_CW, 32'h0);
         settle(2);
         chk({zs, rp, rt, db}, exp_cmd(c));
         if (c == 0) chk(en, 1'b0);
         settle(12);
         chk({en, pl}, 2'b11);
         bw(`SSM_A_CW, 32'h4);
         settle(3);
         bw(`SSM_A_CW, 32'h104);
         settle(2);
         chk({zs, rp, rt, db}, exp_cmd(h));
         bw(`SSM_A_CW, 32'h4);
         settle(12);
      end
      $display("stop modes done");
      // Fault reset held high before the fault must not clear it
      frst <= 1'b1;
      settle(6);
      f1 <= 1'b1;
      settle(1);
      f1 <= 1'b0;
      settle(3);
      chk({fa, db}, 2'b11);
      settle(12);
      chk({fa, db, en}, 3'b110);
      frst <= 1'b0;
      settle(6);
      frst <= 1'b1;
      settle(8);
      chk(fa, 1'b0);
      bw(`SSM_A_CTRL, 32'h5);
      bw(`SSM_A_DLY, 32'h4);
      f2 <= 1'b1;
      settle(1);
      f2 <= 1'b0;
      settle(3);
      chk({zs, bk}, 2'b11);
      settle(20);
      chk({db, en}, 2'b10);
      frst <= 1'b0;
      settle(6);
      frst <= 1'b1;
      settle(8);
      chk(fa, 1'b0);
      bw(`SSM_A_CTRL, 32'h1);
      settle(12);
      // Class-two sequences without brake; the brake delay must not apply
      for (c = 0; c < 5; c++) begin
         bw(`SSM_A_MODE, md(3'h0, 3'h0, 2'h2, c[2:0]));
         f2 <= 1'b1;
         settle(1);
         f2 <= 1'b0;
         settle(3);
         chk({zs, db, en}, c == 0 ? 3'h0 : c < 3 ? 3'h5 : 3'h2);
         settle(10);
         chk({db, en}, {c inside {2, 3}, 1'b0});
         frst <= 1'b0;
         settle(6);
         frst <= 1'b1;
         settle(8);
      end
      $display("faults done");
      est <= 1'b1;
      settle(6);
      chk({we, zs}, 2'b11);
      settle(12);
      chk(pl, 1'b1);
      est <= 1'b0;
      settle(8);
      chk({we, pl}, 2'b00);
      bw(`SSM_A_CTRL, 32'h3);
      settle(2);
      chk(zs, 1'b1);
      bw(`SSM_A_CTRL, 32'h1);
      settle(12);
      $display("emergency stop done");
      flim <= 1'b1;
      rlim <= 1'b1;
      mf <= 1'b1;
      mr <= 1'b1;
      settle(6);
      chk({fi, ri, wl}, 3'b111);
      settle(12);
      chk({pl, en}, 2'b11);
      bw(`SSM_A_CTRL, 32'h19);
      settle(6);
      chk({fi, ri}, 2'b00);
      flim <= 1'b0;
      rlim <= 1'b0;
      settle(6);
      chk({fi, ri}, 2'b11);
      bw(`SSM_A_CTRL, 32'h1);
      mf <= 1'b0;
      mr <= 1'b0;
      settle(12);
      $display("limits done");
      wo <= 1'b1;
      settle(3);
      chk({wos, en, zs, pl}, 4'b1100);
      bw(`SSM_A_CTRL, 32'h0);
      settle(2);
      chk(en, 1'b0);
      settle(12);
      chk({en, db, pl}, 3'b000);
      $display("enable off done");
      stop_test();
   end
endmodule : servo_stop_mode_controller_tb

// [verif/ssm_motor_model.sv]
// Host-side motor model: reports rest once a stop has run long enough
`timescale 1ns/1ps
module ssm_motor_model
   import ssm_pkg::*;
#(
   parameter int STOP_CYC = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic energize,
   input  wire logic stopping,
   input  wire logic hold,
   output logic      at_rest
);
   int cnt_q;

   // Shaft slows while unpowered or stopping; spins up again once freed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 0;
      end else if (stopping || !energize) begin
         cnt_q <= (cnt_q < STOP_CYC) ? cnt_q + 1 : cnt_q;
      end else if (!hold) begin
         cnt_q <= 0;
      end
   end
   // Rest is never shown early, so the stop commands are seen first
   assign at_rest = (cnt_q >= STOP_CYC);
endmodule : ssm_motor_model
